// ==== bench/tb_top.sv ====
// Self-checking bench for the device event block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, hostMode = 1'b0;
	logic usbClockOn = 1'b1, controllerEnable = 1'b1;
	logic [1:0] htrans = 2'b00;
	logic [2:0] hsize = 3'b010;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [62:0] epEventFlags = '0;
	logic hreadyout, hresp, lineIdleJ, sofDetected, sofCrcError, busEndOfReset, endOfResume;
	logic lineWake, usbIrq, cpuResetReq, dpPullup, dmPullup, resumeDrive, addressEnable;
	logic [10:0] sofFrameNumber;
	logic [6:0] setupReceived, endpointInterrupt, deviceAddressValue, endpointFifoResetBits;
	logic [6:0] stallRequest, stallClearPulse, toggleResetPulse;
	int fails = 0, n_tests = 0, cycles = 0, cpuPulses = 0, clrPulses = 0, tglPulses = 0;
	usb_device_event_control #(.SUSPEND_CYCLES(16'h0014), .RESUME_DRIVE_CYCLES(16'h000A))
		usb_device_event_control_i (.clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .lineIdleJ, .sofDetected,
		.sofCrcError, .sofFrameNumber, .busEndOfReset, .endOfResume, .lineWake,
		.setupReceived, .epEventFlags, .hostMode, .usbClockOn, .controllerEnable, .usbIrq,
		.endpointInterrupt, .cpuResetReq, .dpPullup, .dmPullup, .resumeDrive,
		.deviceAddressValue, .addressEnable, .endpointFifoResetBits, .stallRequest,
		.stallClearPulse, .toggleResetPulse);
	usb_host_model usb_host_model_i (.clk, .lineIdleJ, .sofDetected, .sofCrcError,
		.sofFrameNumber, .busEndOfReset, .endOfResume, .lineWake, .setupReceived);
	always #50 clk = ~clk;
	// Run is about 300 cycles; the ceiling leaves ample margin
	always @(posedge clk) begin
		cpuPulses += (cpuResetReq === 1'b1);
		clrPulses += (stallClearPulse[2] === 1'b1);
		tglPulses += (toggleResetPulse[2] === 1'b1);
		cycles++;
		if (cycles > 5000) begin
			fails++;
			report_and_stop();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h00_0000, a};
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h00_0000, d};
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		xfer(a, 1'b0, 8'h00);
		chk(rd, exp);
	endtask
	task automatic t_reset();
		rc(8'h08, 32'h08);
		rc(8'h04, 32'h00);
		rc(8'h00, 32'h01);
		rc(8'h2C, 32'h00);
		chk(32'(hresp), 32'h0);
		chk(32'({dpPullup, dmPullup}), 32'h0);
	endtask
	task automatic t_pullup_connect();
		xfer(8'h00, 1'b1, 8'hF0);
		rc(8'h00, 32'h00);
		chk(32'({dpPullup, dmPullup}), 32'h2);
		xfer(8'h00, 1'b1, 8'h04);
		rc(8'h00, 32'h04);
		chk(32'({dpPullup, dmPullup}), 32'h1);
		hostMode <= 1'b1;
		repeat (2) @(posedge clk);
		chk(32'({dpPullup, dmPullup}), 32'h0);
		hostMode <= 1'b0;
		xfer(8'h00, 1'b1, 8'h05);
		rc(8'h00, 32'h05);
		chk(32'({dpPullup, dmPullup}), 32'h0);
		xfer(8'h00, 1'b1, 8'h00);
	endtask
	task automatic t_bus();
		xfer(8'h0C, 1'b1, 8'h85);
		xfer(8'h0C, 1'b1, 8'h06);
		rc(8'h0C, 32'h86);
		chk(32'({addressEnable, deviceAddressValue}), 32'h86);
		xfer(8'h00, 1'b1, 8'h08);
		usb_host_model_i.pulse(10'h200);
		rc(8'h04, 32'h08);
		chk(32'(usbIrq), 32'h1);
		chk(32'(addressEnable), 32'h0);
		chk(32'(cpuPulses), 32'h1);
		rc(8'h00, 32'h08);
		controllerEnable <= 1'b0;
		rc(8'h00, 32'h00);
		controllerEnable <= 1'b1;
		xfer(8'h04, 1'b1, 8'h00);
	endtask
	task automatic t_sof();
		usb_host_model_i.sof(11'h5A3, 1'b0);
		rc(8'h04, 32'h04);
		rc(8'h10, 32'h05);
		rc(8'h14, 32'hA3);
		rc(8'h18, 32'h00);
		chk(32'(usbIrq), 32'h0);
		usb_host_model_i.sof(11'h27E, 1'b1);
		rc(8'h18, 32'h10);
		rc(8'h10, 32'h02);
		xfer(8'h04, 1'b1, 8'hFF);
		xfer(8'h08, 1'b1, 8'h04);
		rc(8'h04, 32'h04);
		chk(32'(usbIrq), 32'h1);
		xfer(8'h04, 1'b1, 8'hFB);
		rc(8'h04, 32'h00);
		chk(32'(usbIrq), 32'h0);
	endtask
	task automatic t_suspend();
		xfer(8'h00, 1'b1, 8'h02);
		rc(8'h00, 32'h00);
		usb_host_model_i.idle(19);
		rc(8'h04, 32'h00);
		usb_host_model_i.idle(20);
		rc(8'h04, 32'h01);
		xfer(8'h00, 1'b1, 8'h02);
		usb_host_model_i.pulse(10'h080);
		rc(8'h00, 32'h02);
		chk(32'(resumeDrive), 32'h1);
		repeat (12) @(posedge clk);
		rc(8'h04, 32'h41);
		rc(8'h00, 32'h00);
		usbClockOn <= 1'b0;
		xfer(8'h04, 1'b1, 8'h00);
		rc(8'h04, 32'h40);
		usbClockOn <= 1'b1;
		xfer(8'h04, 1'b1, 8'h00);
		rc(8'h04, 32'h00);
		usb_host_model_i.pulse(10'h080);
		rc(8'h04, 32'h10);
		usb_host_model_i.pulse(10'h100);
		rc(8'h04, 32'h30);
	endtask
	task automatic t_endpoint();
		xfer(8'h1C, 1'b1, 8'hFA);
		rc(8'h1C, 32'h02);
		xfer(8'h20, 1'b1, 8'hFF);
		rc(8'h20, 32'h7F);
		chk(32'(endpointFifoResetBits), 32'h7F);
		xfer(8'h20, 1'b1, 8'h00);
		xfer(8'h24, 1'b1, 8'hE0);
		xfer(8'h24, 1'b1, 8'h00);
		rc(8'h24, 32'h20);
		chk(32'(stallRequest), 32'h04);
		usb_host_model_i.pulse(10'h004);
		rc(8'h24, 32'h00);
		xfer(8'h24, 1'b1, 8'h20);
		xfer(8'h24, 1'b1, 8'h18);
		rc(8'h24, 32'h00);
		chk(32'(clrPulses), 32'h1);
		chk(32'(tglPulses), 32'h1);
		for (int i = 0; i < 9; i++) begin
			epEventFlags <= 63'h1 << (27 + i);
			repeat (2) @(posedge clk);
			chk(32'(endpointInterrupt), 32'h08);
		end
		epEventFlags <= '0;
	endtask
	task automatic report_and_stop();
		if (fails == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		t_reset();
		t_pullup_connect();
		t_bus();
		t_sof();
		t_suspend();
		t_endpoint();
		report_and_stop();
	end
endmodule // tb_top
`default_nettype wire

// ==== bench/usb_dev_event_monitor.sv ====
// Port-level assertions for the device event block
`timescale 1ns/10ps
`default_nettype none
module usb_dev_event_monitor #(
	parameter [15:0] RESUME_DRIVE_CYCLES = 16'h000A // Resume length
) (
	input wire clk, // Clock
	input wire rst_b, // Reset, active low
	input wire busEndOfReset, // Bus reset end
	input wire [6:0] setupReceived, // SETUP pulses
	input wire [62:0] epEventFlags, // Endpoint events
	input wire [6:0] endpointInterrupt, // Endpoint irqs
	input wire cpuResetReq, // CPU reset
	input wire dpPullup, // D+ pull-up
	input wire dmPullup, // D- pull-up
	input wire resumeDrive, // Upstream resume
	input wire addressEnable, // Address on
	input wire [6:0] stallRequest, // Stall bits
	input wire [6:0] stallClearPulse, // Stall clear
	input wire [6:0] toggleResetPulse // Toggle reset
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	logic [15:0] runLen;
	// Too long for a repetition, so count the burst
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			runLen <= 16'h0000;
		else
			runLen <= resumeDrive ? runLen + 16'h0001 : 16'h0000;
	end
	ep_irq_or_a: assert property (endpointInterrupt[3] == |$past(epEventFlags[35:27]))
		else $error("endpoint irq");
	cpu_reset_cause_a: assert property (cpuResetReq |-> $past(busEndOfReset))
		else $error("cpu reset");
	pullup_one_a: assert property (!(dpPullup && dmPullup))
		else $error("two pull-ups");
	resume_length_a: assert property ($fell(resumeDrive) |-> runLen == RESUME_DRIVE_CYCLES)
		else $error("resume length");
	setup_unstall_a: assert property (setupReceived[2] |=> !stallRequest[2])
		else $error("stall kept");
	stall_clear_pulse_a: assert property (stallClearPulse != 0 |=> stallClearPulse == 0)
		else $error("stall clear");
	toggle_pulse_a: assert property (toggleResetPulse != 0 |=> toggleResetPulse == 0)
		else $error("toggle reset");
	addr_bus_reset_a: assert property (busEndOfReset |-> ##[1:2] !addressEnable)
		else $error("address kept");
	cover property ($fell(resumeDrive));
	cover property (cpuResetReq);
	cover property (stallClearPulse != 0);
endmodule // usb_dev_event_monitor
bind usb_device_event_control usb_dev_event_monitor #(.RESUME_DRIVE_CYCLES(RESUME_DRIVE_CYCLES))
	usb_dev_event_monitor_i (.clk, .rst_b, .busEndOfReset, .setupReceived, .epEventFlags,
	.endpointInterrupt, .cpuResetReq, .dpPullup, .dmPullup, .resumeDrive, .addressEnable,
	.stallRequest, .stallClearPulse, .toggleResetPulse);
`default_nettype wire

// ==== bench/usb_host_model.sv ====
// Link-side model of the upstream host
`timescale 1ns/10ps
`default_nettype none
module usb_host_model (
	input wire logic clk, // Clock
	output var logic lineIdleJ, // Idle J
	output var logic sofDetected, // SOF pulse
	output var logic sofCrcError, // SOF bad
	output var logic [10:0] sofFrameNumber, // SOF frame
	output var logic busEndOfReset, // Reset end
	output var logic endOfResume, // Resume end
	output var logic lineWake, // Line activity
	output var logic [6:0] setupReceived // SETUP pulses
);
	initial begin
		{lineIdleJ, sofDetected, sofCrcError, sofFrameNumber} = '0;
		{busEndOfReset, endOfResume, lineWake, setupReceived} = '0;
	end
	// Fields are valid only with the pulse, so scramble them after
	task automatic sof(input logic [10:0] fn, input logic crc);
		@(posedge clk);
		{sofDetected, sofCrcError, sofFrameNumber} <= {1'b1, crc, fn};
		@(posedge clk);
		{sofDetected, sofCrcError, sofFrameNumber} <= {1'b0, ~crc, ~fn};
	endtask
	// Order: reset end, resume end, wake, SETUP per endpoint
	task automatic pulse(input logic [9:0] which);
		@(posedge clk);
		{busEndOfReset, endOfResume, lineWake, setupReceived} <= which;
		@(posedge clk);
		{busEndOfReset, endOfResume, lineWake, setupReceived} <= '0;
	endtask
	task automatic idle(input int n);
		@(posedge clk);
		lineIdleJ <= 1'b1;
		repeat (n) @(posedge clk);
		lineIdleJ <= 1'b0;
	endtask
endmodule // usb_host_model
`default_nettype wire

// ==== verilog/usb_dev_event_consts.vh ====
// Register offsets, field positions, reset values and timing for the device event block
`ifndef USB_DEV_EVENT_CONSTS_VH
`define USB_DEV_EVENT_CONSTS_VH

`define CLK_FREQ_MHZ 10
`define SUSPEND_TIME_US 3000
`define RESUME_DRIVE_TIME_US 2000
// Cycle counts at the 10 MHz clock, sized to the 16-bit counters
`define SUSPEND_CYCLES 16'h7530
`define RESUME_DRIVE_CYCLES 16'h4E20

`define ADDR_DEVICE_CONTROL 8'h00
`define ADDR_DEVICE_EVENT_FLAGS 8'h04
`define ADDR_DEVICE_EVENT_ENABLES 8'h08
`define ADDR_DEVICE_ADDRESS 8'h0C
`define ADDR_FRAME_NUMBER_HIGH 8'h10
`define ADDR_FRAME_NUMBER_LOW 8'h14
`define ADDR_FRAME_ERROR_STATUS 8'h18
`define ADDR_ENDPOINT_SELECT 8'h1C
`define ADDR_ENDPOINT_FIFO_RESET 8'h20
`define ADDR_ENDPOINT_CONTROL 8'h24

`define CTL_CPU_RESET_ON_BUS_RESET 3
`define CTL_LOW_SPEED_SELECT 2
`define CTL_REMOTE_WAKE_REQUEST 1
`define CTL_DETACH 0

`define EVT_UPSTREAM_RESUME 6
`define EVT_END_OF_RESUME 5
`define EVT_WAKE 4
`define EVT_END_OF_RESET 3
`define EVT_FRAME_START 2
`define EVT_SUSPEND 0
`define EVT_USED_MASK 8'h7D

`define ENABLES_RESET 8'h08
`define DETACH_RESET 1'b1

`define ADDR_ENABLE_BIT 7
`define FRAME_CRC_ERROR_BIT 4
`define EPC_STALL_REQUEST 5
`define EPC_STALL_REQUEST_CLEAR 4
`define EPC_TOGGLE_RESET 3

`define ENDPOINT_COUNT 7
`define EP_EVENT_COUNT 9

`endif

// ==== verilog/usb_device_event_control.v ====
// Device-level USB event flags, enables, control bits and endpoint control over AHB-Lite
`timescale 1ns/10ps
`default_nettype none
`include "usb_dev_event_consts.vh"

// Functional notes
// - Suspend flag after 3 ms idle J
// - Frame-start flag on every SOF token
// - CRC error flag updated with frame-start
// - Capture 11-bit frame number, even corrupted
// - Flags set regardless of enable bits
// - Upstream resume flag while driving resume
// - End-of-resume flag on host end-of-resume
// - Wake flag on line activity, not self
// - End-of-reset flag; its enable resets set
// - CPU reset on bus reset, bit survives
// - Speed bit picks D+ or D- pull-up
// - Remote wake only while suspended, self-clearing
// - Detach bit disconnects the pull-up
// - Address enable set by software only
// - FIFO reset bits hold endpoint FIFOs
// - Stall request, cleared by new SETUP
// - Stall clear bit disables stall, self-clears
// - Toggle reset forces toggle 0, self-clears
// - Endpoint interrupt on any endpoint event
// - Flags clear only by writing zero
// - Reserved bits read zero, writes ignored
module usb_device_event_control #(
	parameter [15:0] SUSPEND_CYCLES = `SUSPEND_CYCLES, // Idle time before suspend
	parameter [15:0] RESUME_DRIVE_CYCLES = `RESUME_DRIVE_CYCLES // Upstream resume length
) (
	input wire clk, // 10 MHz clock
	input wire rst_b, // Async reset, active low
	input wire hsel, // AHB slave select
	input wire [31:0] haddr, // AHB address
	input wire [1:0] htrans, // AHB transfer type
	input wire hwrite, // AHB write
	input wire [2:0] hsize, // AHB size, word only
	input wire [31:0] hwdata, // AHB write data
	input wire hready, // AHB bus ready
	output reg [31:0] hrdata, // AHB read data
	output reg hreadyout, // AHB slave ready
	output reg hresp, // AHB response, always OKAY
	input wire lineIdleJ, // Bus in idle J state
	input wire sofDetected, // Pulse: SOF token seen
	input wire sofCrcError, // SOF frame number corrupted
	input wire [10:0] sofFrameNumber, // Frame number of the SOF
	input wire busEndOfReset, // Pulse: bus end of reset
	input wire endOfResume, // Pulse: host end of resume
	input wire lineWake, // Pulse: filtered non-idle line
	input wire [6:0] setupReceived, // Pulse per endpoint: new SETUP
	input wire [62:0] epEventFlags, // Nine enabled event flags per endpoint
	input wire hostMode, // Controller in host mode
	input wire usbClockOn, // USB clocks running
	input wire controllerEnable, // Controller enabled
	output reg usbIrq, // Device-level interrupt request
	output reg [6:0] endpointInterrupt, // Per-endpoint interrupt
	output reg cpuResetReq, // Pulse: reset the CPU
	output reg dpPullup, // D+ pull-up on
	output reg dmPullup, // D- pull-up on
	output reg resumeDrive, // Driving upstream resume
	output reg [6:0] deviceAddressValue, // Device address
	output reg addressEnable, // Address active
	output reg [6:0] endpointFifoResetBits, // FIFO reset per endpoint
	output reg [6:0] stallRequest, // Stall request per endpoint
	output reg [6:0] stallClearPulse, // Pulse: stall disabled per endpoint
	output reg [6:0] toggleResetPulse // Pulse: toggle 0 per endpoint
);

	reg rdPend;
	reg wrPend;
	reg [7:0] addrQ;
	reg [7:0] eventFlags;
	reg [7:0] eventEnables;
	reg cpuResetOnBusReset;
	reg lowSpeedSelect;
	reg remoteWakeRequest;
	reg detach;
	reg [10:0] frameNumber;
	reg frameNumberCrcError;
	reg [2:0] endpointNumber;
	reg [15:0] suspendCount;
	reg [15:0] resumeCount;
	reg [7:0] readMux;
	reg [7:0] next_flags;
	wire [7:0] wd;
	wire accept;
	wire wrFlags;
	wire wrCtl;
	wire wrEpCtl;
	wire suspendHit;
	wire [6:0] selOneHot;
	wire [6:0] epAny;

	assign wd = hwdata[7:0];
	assign accept = hsel & htrans[1] & hready;
	assign wrFlags = wrPend & (addrQ == `ADDR_DEVICE_EVENT_FLAGS);
	assign wrCtl = wrPend & (addrQ == `ADDR_DEVICE_CONTROL);
	assign wrEpCtl = wrPend & (addrQ == `ADDR_ENDPOINT_CONTROL);
	assign suspendHit = lineIdleJ & (suspendCount == SUSPEND_CYCLES - 16'h0001);

	genvar ep;
	generate
		for (ep = 0; ep < `ENDPOINT_COUNT; ep = ep + 1) begin : g_ep
			assign selOneHot[ep] = (endpointNumber == ep[2:0]);
			assign epAny[ep] = |epEventFlags[ep*`EP_EVENT_COUNT +: `EP_EVENT_COUNT];
		end
	endgenerate

	// Bus slave: writes take no wait state, reads one so they see the latest write
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdPend <= 1'b0;
			wrPend <= 1'b0;
			addrQ <= 8'h00;
			hreadyout <= 1'b1;
			hrdata <= 32'h0000_0000;
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0;
			wrPend <= accept & hwrite;
			if (accept) begin
				addrQ <= haddr[7:0];
			end
			if (rdPend) begin
				hrdata <= {24'h00_0000, readMux};
				hreadyout <= 1'b1;
				rdPend <= 1'b0;
			end else if (accept & ~hwrite) begin
				rdPend <= 1'b1;
				hreadyout <= 1'b0;
			end
		end
	end

	always @* begin
		case (addrQ)
			`ADDR_DEVICE_CONTROL:
				readMux = {4'h0, cpuResetOnBusReset, lowSpeedSelect, remoteWakeRequest, detach};
			`ADDR_DEVICE_EVENT_FLAGS:
				readMux = eventFlags & `EVT_USED_MASK;
			`ADDR_DEVICE_EVENT_ENABLES:
				readMux = eventEnables & `EVT_USED_MASK;
			`ADDR_DEVICE_ADDRESS:
				readMux = {addressEnable, deviceAddressValue};
			`ADDR_FRAME_NUMBER_HIGH:
				readMux = {5'h00, frameNumber[10:8]};
			`ADDR_FRAME_NUMBER_LOW:
				readMux = frameNumber[7:0];
			`ADDR_FRAME_ERROR_STATUS:
				readMux = {3'h0, frameNumberCrcError, 4'h0};
			`ADDR_ENDPOINT_SELECT:
				readMux = {5'h00, endpointNumber};
			`ADDR_ENDPOINT_FIFO_RESET:
				readMux = {1'b0, endpointFifoResetBits};
			`ADDR_ENDPOINT_CONTROL:
				readMux = {2'h0, |(stallRequest & selOneHot), 5'h00};
			default:
				readMux = 8'h00;
		endcase
	end

	// Hardware set wins over a software clear in the same cycle
	always @* begin
		next_flags = eventFlags;
		if (wrFlags) begin
			next_flags[`EVT_END_OF_RESUME] = eventFlags[`EVT_END_OF_RESUME] & wd[`EVT_END_OF_RESUME];
			next_flags[`EVT_END_OF_RESET] = eventFlags[`EVT_END_OF_RESET] & wd[`EVT_END_OF_RESET];
			next_flags[`EVT_FRAME_START] = eventFlags[`EVT_FRAME_START] & wd[`EVT_FRAME_START];
			next_flags[`EVT_SUSPEND] = eventFlags[`EVT_SUSPEND] & wd[`EVT_SUSPEND];
			// These two need the USB clocks running before a clear takes hold
			if (usbClockOn) begin
				next_flags[`EVT_UPSTREAM_RESUME] = eventFlags[`EVT_UPSTREAM_RESUME]
					& wd[`EVT_UPSTREAM_RESUME];
				next_flags[`EVT_WAKE] = eventFlags[`EVT_WAKE] & wd[`EVT_WAKE];
			end
		end
		if (resumeDrive) begin
			next_flags[`EVT_UPSTREAM_RESUME] = 1'b1;
		end
		if (endOfResume) begin
			next_flags[`EVT_END_OF_RESUME] = 1'b1;
		end
		if (lineWake & ~resumeDrive) begin
			next_flags[`EVT_WAKE] = 1'b1;
		end
		if (busEndOfReset) begin
			next_flags[`EVT_END_OF_RESET] = 1'b1;
		end
		if (sofDetected) begin
			next_flags[`EVT_FRAME_START] = 1'b1;
		end
		if (suspendHit) begin
			next_flags[`EVT_SUSPEND] = 1'b1;
		end
		next_flags = next_flags & `EVT_USED_MASK;
	end

	// Event flags, enables and the interrupt request
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			eventFlags <= 8'h00;
			eventEnables <= `ENABLES_RESET;
			usbIrq <= 1'b0;
		end else begin
			eventFlags <= next_flags;
			if (wrPend & (addrQ == `ADDR_DEVICE_EVENT_ENABLES)) begin
				eventEnables <= wd & `EVT_USED_MASK;
			end
			usbIrq <= |(eventFlags & eventEnables);
		end
	end

	// Idle counter saturates so the flag is set once per idle period
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			suspendCount <= 16'h0000;
		end else if (!lineIdleJ) begin
			suspendCount <= 16'h0000;
		end else if (suspendCount < SUSPEND_CYCLES) begin
			suspendCount <= suspendCount + 16'h0001;
		end
	end

	// Frame number and its CRC flag move together with the frame-start flag
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			frameNumber <= 11'h000;
			frameNumberCrcError <= 1'b0;
		end else if (sofDetected) begin
			frameNumber <= sofFrameNumber;
			frameNumberCrcError <= sofCrcError;
		end
	end

	// Device control bits and remote wake-up signalling
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cpuResetOnBusReset <= 1'b0;
			lowSpeedSelect <= 1'b0;
			remoteWakeRequest <= 1'b0;
			detach <= `DETACH_RESET;
			resumeDrive <= 1'b0;
			resumeCount <= 16'h0000;
			cpuResetReq <= 1'b0;
		end else begin
			cpuResetReq <= busEndOfReset & cpuResetOnBusReset;
			if (wrCtl) begin
				lowSpeedSelect <= wd[`CTL_LOW_SPEED_SELECT];
				detach <= wd[`CTL_DETACH];
			end
			// Survives the CPU reset it causes; only disabling the controller drops it
			if (!controllerEnable) begin
				cpuResetOnBusReset <= 1'b0;
			end else if (wrCtl) begin
				cpuResetOnBusReset <= wd[`CTL_CPU_RESET_ON_BUS_RESET];
			end
			if (resumeDrive) begin
				if (resumeCount == RESUME_DRIVE_CYCLES - 16'h0001) begin
					resumeDrive <= 1'b0;
					remoteWakeRequest <= 1'b0;
					resumeCount <= 16'h0000;
				end else begin
					resumeCount <= resumeCount + 16'h0001;
				end
			end else if (wrCtl & wd[`CTL_REMOTE_WAKE_REQUEST] & eventFlags[`EVT_SUSPEND]) begin
				remoteWakeRequest <= 1'b1;
				resumeDrive <= 1'b1;
				resumeCount <= 16'h0000;
			end
		end
	end

	// Pull-ups follow detach and speed; speed has no say in host mode
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dpPullup <= 1'b0;
			dmPullup <= 1'b0;
		end else begin
			dpPullup <= ~detach & ~hostMode & ~lowSpeedSelect;
			dmPullup <= ~detach & ~hostMode & lowSpeedSelect;
		end
	end

	// Address: enable is set by software and dropped by hardware on bus reset
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			deviceAddressValue <= 7'h00;
			addressEnable <= 1'b0;
		end else if (busEndOfReset) begin
			addressEnable <= 1'b0;
		end else if (wrPend & (addrQ == `ADDR_DEVICE_ADDRESS)) begin
			deviceAddressValue <= wd[6:0];
			if (wd[`ADDR_ENABLE_BIT]) begin
				addressEnable <= 1'b1;
			end
		end
	end

	// Endpoint selection and FIFO resets
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			endpointNumber <= 3'h0;
			endpointFifoResetBits <= 7'h00;
		end else begin
			// Value seven is not guarded; no endpoint then answers
			if (wrPend & (addrQ == `ADDR_ENDPOINT_SELECT)) begin
				endpointNumber <= wd[2:0];
			end
			if (wrPend & (addrQ == `ADDR_ENDPOINT_FIFO_RESET)) begin
				endpointFifoResetBits <= wd[6:0];
			end
		end
	end

	// Per-endpoint stall, toggle reset and interrupt
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			stallRequest <= 7'h00;
			stallClearPulse <= 7'h00;
			toggleResetPulse <= 7'h00;
			endpointInterrupt <= 7'h00;
		end else begin
			endpointInterrupt <= epAny;
			stallClearPulse <= {7{wrEpCtl & wd[`EPC_STALL_REQUEST_CLEAR]}} & selOneHot;
			toggleResetPulse <= {7{wrEpCtl & wd[`EPC_TOGGLE_RESET]}} & selOneHot;
			stallRequest <= (stallRequest
				| ({7{wrEpCtl & wd[`EPC_STALL_REQUEST]}} & selOneHot))
				& ~({7{wrEpCtl & wd[`EPC_STALL_REQUEST_CLEAR]}} & selOneHot)
				& ~setupReceived;
		end
	end

endmodule // usb_device_event_control
`default_nettype wire
